// >>> design/tgt_top.sv
// module: tone generator timer with AXI4-Lite registers and buzzer pin routing
//
// The AXI4-Lite slave port was chosen for this implementation.
module tgt_top #(
  parameter int DIV_W = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // subsystem clock as a one-cycle enable
  input wire logic subsys_tick,
  // axi4-lite write address and data
  input wire logic [tgt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [tgt_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt and buzzer pins
  output logic tone_irq,
  output tgt_pkg::tgt_pins_type sound_pins
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] port3_function_ctrl_ff;
  logic [7:0] tone_timer_mode_ff;
  logic [2:0] tone_output_ctrl_ff;
  logic [7:0] tone_freq_select_ff;
  logic [7:0] tone_compare_ff;
  logic [7:0] tone_count_ff;
  logic irq_status_ff;
  logic irq_mask_ff;
  logic [tgt_pkg::PRE_W-1:0] pre_ff;
  logic [DIV_W-1:0] div_ff;
  logic carrier_ff;
  logic tone_irq_ff;
  tgt_pkg::tgt_pins_type pins_ff;
  logic awready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  // prescaler tap decode, used for several rates
  function automatic logic tap_hit(input logic [14:0] pre, input logic [14:0] mask);
    tap_hit = (pre & mask) == mask;
  endfunction

  // register index decode, used for both read and write
  function automatic logic [15:0] reg_index(input logic [tgt_pkg::ADDR_W-1:0] addr);
    reg_index = addr[tgt_pkg::ADDR_W-1:2];
  endfunction

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  // address and data are taken together once both are offered
  logic wr_take;
  logic wr_en;
  logic [15:0] wr_idx;
  logic [7:0] wr_byte;
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
  assign wr_idx = reg_index(s_axi_awaddr);
  assign wr_byte = s_axi_wdata[7:0];
  assign wr_en = wr_take && s_axi_wstrb[0];

  logic wr_mapped;
  always_comb begin
    case (wr_idx)
      tgt_pkg::IDX_PORT3_FUNC, tgt_pkg::IDX_TIMER_MODE, tgt_pkg::IDX_OUT_CTRL,
      tgt_pkg::IDX_FREQ_SEL, tgt_pkg::IDX_COMPARE, tgt_pkg::IDX_COUNT,
      tgt_pkg::IDX_IRQ_STATUS, tgt_pkg::IDX_IRQ_MASK: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  // ready pulses one cycle; response is raised on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= tgt_pkg::RESP_OKAY;
    end else begin
      awready_ff <= wr_take;
      if (wr_take) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_mapped ? tgt_pkg::RESP_OKAY : tgt_pkg::RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // clock generation: prescaler and carrier divider
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + 1'b1;
    end
  end

  logic src_tick;
  logic carrier_tick;
  logic [DIV_W-1:0] divisor;
  assign divisor = tone_freq_select_ff[DIV_W-1:0];
  // source is subsystem tick or main / 2^7 [R10]
  assign src_tick = tone_freq_select_ff[tgt_pkg::SRC_SEL_BIT] ?
                    tap_hit(pre_ff, tgt_pkg::TAP_DIV7) : subsys_tick; // [R10]
  // one carrier period per divisor+1 source ticks [R11]
  assign carrier_tick = src_tick && (div_ff >= divisor); // [R11]

  // carrier high over the first half of each divided period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      carrier_ff <= 1'b0;
    end else if (src_tick) begin
      div_ff <= carrier_tick ? '0 : div_ff + 1'b1; // [R11]
      // divisor of zero cannot split a source period, so it stays high
      carrier_ff <= carrier_tick ? 1'b1 : ((div_ff + 1'b1) <= (divisor >> 1)); // [R19]
    end
  end

  // ---------------------------------------------------------------
  // tone timer count and compare
  // ---------------------------------------------------------------
  logic count_tick;
  logic match;
  always_comb begin
    case (tone_timer_mode_ff[tgt_pkg::CLK_SEL_LO +: 2])
      tgt_pkg::CSEL_DIV13: count_tick = tap_hit(pre_ff, tgt_pkg::TAP_DIV13); // [R5]
      tgt_pkg::CSEL_DIV14: count_tick = tap_hit(pre_ff, tgt_pkg::TAP_DIV14); // [R5]
      tgt_pkg::CSEL_DIV15: count_tick = tap_hit(pre_ff, tgt_pkg::TAP_DIV15); // [R5]
      default: count_tick = carrier_tick; // [R5]
    endcase
  end
  // match is judged on the tick that would pass the compare value [R1]
  assign match = tone_timer_mode_ff[tgt_pkg::RUN_BIT] && count_tick &&
                 (tone_count_ff == tone_compare_ff); // [R1]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_count_ff <= tgt_pkg::RST_BYTE; // [R3]
    end else if (!tone_timer_mode_ff[tgt_pkg::RUN_BIT]) begin
      tone_count_ff <= tgt_pkg::RST_BYTE; // [R4]
    end else if (match) begin
      tone_count_ff <= tgt_pkg::RST_BYTE; // [R18]
    end else if (count_tick) begin
      tone_count_ff <= tone_count_ff + 1'b1; // [R4]
    end
  end

  // compare has no reset value; software loads it before starting [R2]
  always_ff @(posedge aclk) begin
    if (wr_en && wr_idx == tgt_pkg::IDX_COMPARE) begin
      tone_compare_ff <= wr_byte; // [R2]
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port3_function_ctrl_ff <= tgt_pkg::RST_BYTE; // [R14]
      tone_timer_mode_ff <= tgt_pkg::RST_BYTE; // [R12]
      tone_freq_select_ff <= tgt_pkg::RST_BYTE; // [R12]
      irq_mask_ff <= 1'b0;
    end else if (wr_en) begin
      case (wr_idx)
        tgt_pkg::IDX_PORT3_FUNC: port3_function_ctrl_ff <= wr_byte & tgt_pkg::PF_MASK; // [R14]
        tgt_pkg::IDX_TIMER_MODE: tone_timer_mode_ff <= wr_byte & tgt_pkg::TMODE_MASK;
        tgt_pkg::IDX_FREQ_SEL: tone_freq_select_ff <= wr_byte;
        tgt_pkg::IDX_IRQ_MASK: irq_mask_ff <= wr_byte[0];
        default: ;
      endcase
    end
  end

  // output control: a whole-byte write sets all three bits; only low bits kept [R8] [R9]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_output_ctrl_ff <= 3'h0; // [R12]
    end else if (wr_en && wr_idx == tgt_pkg::IDX_OUT_CTRL) begin
      tone_output_ctrl_ff <= wr_byte[2:0]; // [R8]
    end else if (match) begin
      tone_output_ctrl_ff[tgt_pkg::OUT_BIT] <= tone_output_ctrl_ff[tgt_pkg::NEXT_BIT]; // [R7]
    end
  end

  // ---------------------------------------------------------------
  // interrupt: sticky status, write one to clear, set wins
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_ff <= 1'b0;
    end else if (match) begin
      irq_status_ff <= 1'b1; // [R1]
    end else if (wr_en && wr_idx == tgt_pkg::IDX_IRQ_STATUS && wr_byte[0]) begin
      irq_status_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tone_irq_ff <= 1'b0;
    end else begin
      tone_irq_ff <= (irq_status_ff || match) && irq_mask_ff;
    end
  end

  // ---------------------------------------------------------------
  // output stage and pin routing
  // ---------------------------------------------------------------
  logic tone_level;
  logic [2:0] pf_mode;
  logic [3:0] pf_enable;
  tgt_pkg::tgt_pins_type nxt_pins;
  assign pf_mode = port3_function_ctrl_ff[2:0];
  assign pf_enable = port3_function_ctrl_ff[tgt_pkg::PF_OE_LO +: 4];

  always_comb begin
    case ({tone_output_ctrl_ff[tgt_pkg::RMC_BIT], tone_output_ctrl_ff[tgt_pkg::OUT_BIT]})
      2'h1: tone_level = carrier_ff; // [R6]
      2'h3: tone_level = 1'b1; // [R6]
      default: tone_level = 1'b0; // [R6]
    endcase
  end

  // lower pin n carries the tone, pin n+4 its inverse; each pair gated by its enable
  always_comb begin
    nxt_pins = '0;
    for (int n = 0; n < 4; n++) begin
      nxt_pins.level[n] = tone_level; // [R13]
      nxt_pins.level[n + 4] = !tone_level; // [R17]
    end
    case (pf_mode)
      tgt_pkg::MODE_BUZZ0: begin
        nxt_pins.oe[0] = pf_enable[0]; // [R16]
        nxt_pins.level[4] = 1'b0;
      end
      tgt_pkg::MODE_BUZZ1, tgt_pkg::MODE_BUZZ2: begin
        nxt_pins.oe[0] = pf_enable[0]; // [R15]
        nxt_pins.oe[4] = pf_enable[0]; // [R16]
        nxt_pins.pull = (pf_mode == tgt_pkg::MODE_BUZZ2) ? 8'hff : 8'h00; // [R16]
      end
      tgt_pkg::MODE_BUZZ3: begin
        nxt_pins.oe = {pf_enable, pf_enable}; // [R17] [R15]
      end
      default: nxt_pins.level = 8'h00; // port mode or prohibited code: pins released
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_ff <= '0;
    end else begin
      pins_ff <= nxt_pins; // [R13]
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic rd_take;
  logic [15:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_mapped;
  assign rd_take = s_axi_arvalid && !arready_ff && !rvalid_ff;
  assign rd_idx = reg_index(s_axi_araddr);

  // output control is write only and reads as zero
  always_comb begin
    rd_mapped = 1'b1;
    case (rd_idx)
      tgt_pkg::IDX_PORT3_FUNC: rd_byte = port3_function_ctrl_ff;
      tgt_pkg::IDX_TIMER_MODE: rd_byte = tone_timer_mode_ff;
      tgt_pkg::IDX_OUT_CTRL: rd_byte = 8'h00;
      tgt_pkg::IDX_FREQ_SEL: rd_byte = tone_freq_select_ff;
      tgt_pkg::IDX_COMPARE: rd_byte = tone_compare_ff;
      tgt_pkg::IDX_COUNT: rd_byte = tone_count_ff; // [R3]
      tgt_pkg::IDX_IRQ_STATUS: rd_byte = {7'h00, irq_status_ff};
      tgt_pkg::IDX_IRQ_MASK: rd_byte = {7'h00, irq_mask_ff};
      default: begin
        rd_byte = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= tgt_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      arready_ff <= rd_take;
      if (rd_take) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= {24'h00_0000, rd_byte};
        rresp_ff <= rd_mapped ? tgt_pkg::RESP_OKAY : tgt_pkg::RESP_SLVERR;
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign tone_irq = tone_irq_ff;
  assign sound_pins = pins_ff;

endmodule // tgt_top

// >>> design/tgt_pkg.sv
// package: register map, field layout and timing constants for the tone generator timer
// Notes on behaviour
// [R1] compare register checked against count; equality raises the tone match interrupt
// [R2] compare register is not initialised by reset; software loads it first
// [R3] reset clears the count; software reads it as a whole byte only
// [R4] run bit 7 low clears and halts the count; high lets it count
// [R5] clock select: main/2^13, main/2^14, main/2^15, or the tone carrier
// [R6] output: low, carrier, low, high for remote mode and output bit pairs
// [R7] next-level bit is copied into the output bit on every match; a write to output control in the same cycle wins
// [R8] software writes the output control register as a whole byte only
// [R9] software writes zeros into bits 3 to 7 of output control
// [R10] frequency bit 7 selects subsystem clock (0) or main clock / 2^7 (1)
// [R11] seven-bit divisor field divides the selected source by value plus one
// [R12] reset clears frequency, timer mode and output control registers
// [R13] tone is delivered on selectable port pins besides the interrupt
// [R14] port function register resets to zero; enables above, mode below
// [R15] enable bit n drives pin n and pin n+4, clear disables both
// [R16] mode 000 port, 001 pin 0, 010/011 pin 0 and inverted pin 4
// [R17] mode 100 drives all eight pins, upper four inverted, pulls off
// [R18] a match clears the count and counting goes on
// [R19] carrier is a square wave at the divided source rate; code holds it high at divisor 0, high one tick longer at even divisors
package tgt_pkg;

  // ---------------------------------------------------------------
  // register indices; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] IDX_PORT3_FUNC = 16'hff53;
  localparam logic [15:0] IDX_TIMER_MODE = 16'hff6b;
  localparam logic [15:0] IDX_OUT_CTRL = 16'hff6c;
  localparam logic [15:0] IDX_FREQ_SEL = 16'hff6d;
  localparam logic [15:0] IDX_COMPARE = 16'hff6e;
  localparam logic [15:0] IDX_COUNT = 16'hff6f;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hff70;
  localparam logic [15:0] IDX_IRQ_MASK = 16'hff71;
  localparam int ADDR_W = 18;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int RUN_BIT = 7;
  localparam int CLK_SEL_LO = 3;
  localparam int RMC_BIT = 2;
  localparam int NEXT_BIT = 1;
  localparam int OUT_BIT = 0;
  localparam int SRC_SEL_BIT = 7;
  localparam int PF_OE_LO = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] TMODE_MASK = 8'h98;
  localparam logic [7:0] PF_MASK = 8'hf7;

  // ---------------------------------------------------------------
  // count clock select and buzzer mode encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] CSEL_DIV13 = 2'h0;
  localparam logic [1:0] CSEL_DIV14 = 2'h1;
  localparam logic [1:0] CSEL_DIV15 = 2'h2;
  localparam logic [2:0] MODE_BUZZ0 = 3'h1;
  localparam logic [2:0] MODE_BUZZ1 = 3'h2;
  localparam logic [2:0] MODE_BUZZ2 = 3'h3;
  localparam logic [2:0] MODE_BUZZ3 = 3'h4;

  // ---------------------------------------------------------------
  // prescaler taps as masks of low prescaler bits
  // ---------------------------------------------------------------
  localparam int PRE_W = 15;
  localparam logic [14:0] TAP_DIV7 = 15'h007f;
  localparam logic [14:0] TAP_DIV13 = 15'h1fff;
  localparam logic [14:0] TAP_DIV14 = 15'h3fff;
  localparam logic [14:0] TAP_DIV15 = 15'h7fff;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins toward the buzzer
  typedef struct packed {
    logic [7:0] level;
    logic [7:0] oe;
    logic [7:0] pull;
  } tgt_pins_type;

endpackage

// >>> verification/tgt_chk.sv
// checker: port-level properties of the tone generator timer
module tgt_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // interrupt and pins
  input wire logic tone_irq,
  input wire tgt_pkg::tgt_pins_type sound_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----
  // bus take sequences
  // ----
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_take |=>
    s_axi_awready && s_axi_wready && s_axi_bvalid ##1 !s_axi_awready)
    else $error("write not answered");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_read_answer: assert property (rd_take |=> s_axi_arready && s_axi_rvalid
    ##1 !s_axi_arready) else $error("read not answered");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte");
  a_reset_quiet: assert property ($rose(aresetn) |-> sound_pins == '0 && !tone_irq)
    else $error("outputs active after reset");
  // pins: an upper enable comes only with its lower pin, upper half is the inverted tone
  a_pair_enable: assert property ((sound_pins.oe[7:4] & ~sound_pins.oe[3:0]) == 4'h0)
    else $error("upper pin enabled alone");
  a_pin4_inverse: assert property (sound_pins.oe[4] |->
    sound_pins.level[4] != sound_pins.level[0]) else $error("pin 4 not inverse");
  a_upper_inverse: assert property (|sound_pins.oe[7:5] |->
    sound_pins.level[7:5] == ~sound_pins.level[3:1]) else $error("upper pins not inverse");
  a_pull_pair: assert property (|sound_pins.pull |-> sound_pins.oe[7:5] == 3'h0
    && sound_pins.oe[3:1] == 3'h0) else $error("pulls outside two-pin mode");
  // clearing needs a full bus write, so the level cannot drop sooner
  a_irq_steady: assert property ($rose(tone_irq) |=> tone_irq [*2])
    else $error("interrupt not held");
endmodule // tgt_chk

// >>> verification/tgt_buzz.sv
// partner: buzzer on the sound pins, resolves wires and counts tones
module tgt_buzz (
  // clock
  input wire logic aclk,
  // pins from the block
  input wire tgt_pkg::tgt_pins_type pins,
  // resolved wires and rising edges on pin 0
  output logic [7:0] wire_lvl,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ns;
  // one process owns both outputs; an undriven wire without pull wanders,
  // so a stale level never passes
  initial begin
    wire_lvl = 8'h00;
    rises = 0;
    forever begin
      @(posedge aclk);
      for (int n = 0; n < 8; n++)
        wire_lvl[n] <= pins.oe[n] ? pins.level[n] : (pins.pull[n] | ~wire_lvl[n]);
      if (pins.oe[0] && pins.level[0] && !wire_lvl[0])
        rises <= rises + 1;
    end
  end
endmodule // tgt_buzz

// >>> verification/tone_generator_timer_bench.sv
// testbench: tone generator timer against a register and tone model
module tone_generator_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn = 1'b0, subsys_tick = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tone_irq;
  tgt_pkg::tgt_pins_type sound_pins;
  logic [7:0] wire_lvl, d;
  logic [31:0] rng = 32'h93a2a3af;
  int rises, miscompares = 0, n_tests = 0, cyc = 0, t0, t1, e0, mdl[6];
  logic [15:0] ix_t[6] = '{tgt_pkg::IDX_PORT3_FUNC, tgt_pkg::IDX_TIMER_MODE,
    tgt_pkg::IDX_OUT_CTRL, tgt_pkg::IDX_FREQ_SEL, tgt_pkg::IDX_COMPARE, tgt_pkg::IDX_IRQ_MASK};
  logic [7:0] rm_t[6] = '{tgt_pkg::PF_MASK, tgt_pkg::TMODE_MASK, 8'h00, 8'hff, 8'hff, 8'h01};
  logic [7:0] pf_t[5] = '{8'h11, 8'h12, 8'h13, 8'hf4, 8'hf0};
  logic [7:0] oe_t[5] = '{8'h01, 8'h11, 8'h11, 8'hff, 8'h00};
  logic [7:0] fq_t[4] = '{8'h01, 8'h03, 8'h07, 8'h81};

  tgt_top dut_u (.aclk, .aresetn, .subsys_tick, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tone_irq, .sound_pins);
  tgt_buzz buzz_u (.aclk, .pins(sound_pins), .wire_lvl, .rises);

  // ----
  // clock, subsystem tick every second cycle, cycle count
  // ----
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) subsys_tick <= ~subsys_tick;
  always @(posedge aclk) cyc <= cyc + 1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (e !== g) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // bus master: hold each channel until its ready, answers waited under a bound
  task automatic wr(input logic [15:0] ix, input logic [7:0] v);
    int g;
    g = 0;
    @(posedge aclk);
    s_axi_awaddr <= {ix, 2'b00};
    s_axi_wdata <= {rng[31:8], v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      g++;
      if (s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!s_axi_bvalid && g < 50);
    if (!s_axi_bvalid) miscompares++; // write answer never came
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    rng = xs(rng);
  endtask

  task automatic rd(input logic [15:0] ix);
    int g;
    g = 0;
    @(posedge aclk);
    s_axi_araddr <= {ix, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      g++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && g < 50);
    if (!s_axi_rvalid) miscompares++; // read answer never came
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rise(output int t);
    int g;
    g = 0;
    do begin
      @(posedge aclk);
      g++;
    end while (!tone_irq && g < 40000);
    if (!tone_irq) miscompares++; // interrupt never came
    t = cyc;
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard: the count clock tests need at most about 82k cycles, the rest a few k
  initial begin
    repeat (98000) @(posedge aclk);
    miscompares++;
    tally_and_finish;
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values, the compare register is left unchecked on purpose
    for (int i = 0; i < 6; i++) begin
      rd(ix_t[i]);
      if (i != 4) ck("reset value", 8'h00, d);
    end
    rd(tgt_pkg::IDX_COUNT);
    ck("count reset", 8'h00, d);
    rd(16'hff60);
    ck("unmapped read", {tgt_pkg::RESP_SLVERR, 8'h00}, {r, d});
    wr(16'hff60, 8'hff);
    ck("unmapped write", tgt_pkg::RESP_SLVERR, r);
    $display("test reset values done");
    // random whole-byte writes, output control upper bits kept clear
    for (int i = 0; i < 6; i++) begin
      mdl[i] = (i == 2) ? rng[2:0] : rng[7:0];
      wr(ix_t[i], mdl[i][7:0]);
    end
    for (int i = 0; i < 6; i++) begin
      rd(ix_t[i]);
      ck("readback", mdl[i][7:0] & rm_t[i], d);
    end
    $display("test register access done");
    // prescaled count clocks with compare zero: one match per tick
    wr(tgt_pkg::IDX_COMPARE, 8'h00);
    wr(tgt_pkg::IDX_IRQ_MASK, 8'h01);
    wr(tgt_pkg::IDX_OUT_CTRL, 8'h00);
    for (int c = 0; c < 3; c++) begin
      wr(tgt_pkg::IDX_TIMER_MODE, 8'h00);
      wr(tgt_pkg::IDX_IRQ_STATUS, 8'h01);
      wr(tgt_pkg::IDX_TIMER_MODE, {1'b1, 2'b00, c[1:0], 3'b000});
      rise(t0);
      wr(tgt_pkg::IDX_IRQ_STATUS, 8'h01);
      rd(tgt_pkg::IDX_IRQ_STATUS);
      ck("status cleared", 8'h00, {d, tone_irq});
      if (c < 2) begin
        rise(t1);
        ck("match period", 1 << (13 + c), t1 - t0);
      end
    end
    $display("test count clocks done");
    // carrier count clock, output stage and pin routing
    wr(tgt_pkg::IDX_IRQ_MASK, 8'h00);
    wr(tgt_pkg::IDX_FREQ_SEL, 8'h01);
    wr(tgt_pkg::IDX_COMPARE, 8'h09);
    wr(tgt_pkg::IDX_TIMER_MODE, 8'h98);
    // next bit kept high so a match during the sweep leaves the level high
    wr(tgt_pkg::IDX_OUT_CTRL, 8'h07);
    for (int j = 0; j < 5; j++) begin
      wr(tgt_pkg::IDX_PORT3_FUNC, pf_t[j]);
      repeat (2) @(posedge aclk);
      ck("pin enables", oe_t[j], sound_pins.oe);
      ck("pulls", (j == 2) ? 8'hff : 8'h00, sound_pins.pull);
      if (j == 2) ck("pulled wire", 1'b1, wire_lvl[1]);
      ck("pin levels", oe_t[j] & 8'h0f, sound_pins.level & sound_pins.oe);
    end
    wr(tgt_pkg::IDX_PORT3_FUNC, 8'h11);
    wr(tgt_pkg::IDX_OUT_CTRL, 8'h04);
    repeat (3) @(posedge aclk);
    ck("remote low", 1'b0, sound_pins.level[0]);
    wr(tgt_pkg::IDX_OUT_CTRL, 8'h02);
    repeat (60) @(posedge aclk);
    rd(tgt_pkg::IDX_IRQ_STATUS);
    ck("masked match", 2'b10, {d[0], tone_irq});
    for (int k = 0; k < 4; k++) begin
      wr(tgt_pkg::IDX_FREQ_SEL, fq_t[k]);
      repeat (600) @(posedge aclk);
      e0 = rises;
      repeat (1024) @(posedge aclk);
      ck("carrier edges", 1024 / ((fq_t[k][6:0] + 1) * (fq_t[k][7] ? 128 : 2)),
        rises - e0);
    end
    wr(tgt_pkg::IDX_FREQ_SEL, 8'h01);
    wr(tgt_pkg::IDX_OUT_CTRL, 8'h01);
    repeat (100) @(posedge aclk);
    e0 = rises;
    repeat (100) @(posedge aclk);
    ck("carrier stopped", 0, rises - e0);
    wr(tgt_pkg::IDX_IRQ_MASK, 8'h01);
    repeat (2) @(posedge aclk);
    ck("irq unmasked", 1'b1, tone_irq);
    wr(tgt_pkg::IDX_TIMER_MODE, 8'h18);
    rd(tgt_pkg::IDX_COUNT);
    ck("count stopped", 8'h00, d);
    $display("test tone output done");
    tally_and_finish;
  end
endmodule // tone_generator_timer_bench

bind tgt_top tgt_chk chk_u (.aclk, .aresetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_awready,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .tone_irq, .sound_pins);
